// ---- rtl/uhbt_pkg.sv ----
// uhbt_pkg: constants and types for the uart host/baud/transmit core
// assumes: one 20 MHz clock, registers reached over the 8-bit async host port

package uhbt_pkg;

    // ----------------------------------------
    // host port
    // ----------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_IER = 3'h1;
    localparam logic [2:0] OFS_FCR = 3'h2;
    localparam logic [2:0] OFS_LCR = 3'h3;
    localparam logic [2:0] OFS_MCR = 3'h4;
    localparam logic [2:0] OFS_LSR = 3'h5;
    localparam logic [2:0] OFS_SPR = 3'h7;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int IER_RX_EN = 0;
    localparam int IER_TX_EN = 1;
    localparam int FCR_FIFO_EN = 0;
    localparam int FCR_TX_RESET = 2;
    localparam int FCR_BLOCK_XFER = 3;
    localparam int FCR_TX_TRIG_LO = 4;
    localparam int LCR_STOP2 = 2;
    localparam int LCR_PAR_EN = 3;
    localparam int LCR_PAR_EVEN = 4;
    localparam int LCR_DIV_ACCESS = 7;
    localparam int MCR_PRESCALE = 7;
    localparam int LSR_RX_READY = 0;
    localparam int LSR_THR_EMPTY = 5;
    localparam int LSR_TX_EMPTY = 6;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] DIV_LOW_RST = 8'h01;
    localparam logic [7:0] DIV_HIGH_RST = 8'h00;
    localparam logic [7:0] IER_RST = 8'h00;
    localparam logic [7:0] FCR_RST = 8'h00;
    localparam logic [7:0] LCR_RST = 8'h03;
    localparam logic [7:0] MCR_RST = 8'h00;
    localparam logic [7:0] SPR_RST = 8'h00;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int RESET_MIN_NS = 40;
    localparam int RESET_MIN_CYC_RAW = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_MIN_CYC = (RESET_MIN_CYC_RAW < 1) ? 1 : RESET_MIN_CYC_RAW;
    localparam logic [1:0] PRESCALE_SLOW_LAST = 2'h3;
    localparam logic [3:0] BIT_TICKS_LAST = 4'hF;
    localparam int TX_FIFO_DEPTH = 16;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_START,
        TX_DATA,
        TX_PARITY,
        TX_STOP
    } uhbt_tx_state_t;

    // transmit trigger level from the two fifo_control bits
    function automatic logic [4:0] uhbt_tx_trigger(input logic [1:0] sel);
        case (sel)
            2'h0: uhbt_tx_trigger = 5'h01;
            2'h1: uhbt_tx_trigger = 5'h04;
            2'h2: uhbt_tx_trigger = 5'h08;
            default: uhbt_tx_trigger = 5'h0E;
        endcase
    endfunction : uhbt_tx_trigger

endpackage : uhbt_pkg

// ---- rtl/uhbt_fifo_if.sv ----
// uhbt_fifo_if: valid/ready link between the core and its transmit fifo
// assumes: both ends on sys_clk

interface uhbt_fifo_if #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    logic [$clog2(DEPTH+1)-1:0] level;
    logic flush;

    modport core (
        output in_valid, in_data, out_ready, flush,
        input in_ready, out_valid, out_data, level
    );
    modport fifo (
        input in_valid, in_data, out_ready, flush,
        output in_ready, out_valid, out_data, level
    );
endinterface : uhbt_fifo_if

// ---- rtl/uhbt_fifo.sv ----
// uhbt_fifo: parameterised synchronous fifo with valid/ready on both sides
// assumes: single clock, synchronous active-high reset

module uhbt_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic srst,
    uhbt_fifo_if.fifo f
);
    import uhbt_pkg::*;

    localparam int PW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);

    generate
        if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
            $error("uhbt_fifo: DEPTH must be a power of two, at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [LW-1:0] count, next_count;
    logic push, pop;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        push = f.in_valid && (count != LW'(DEPTH));
        pop = f.out_ready && (count != '0);
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (f.flush) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count = '0;
        end else begin
            if (push) begin
                next_wr_ptr = wr_ptr + PW'(1);
            end
            if (pop) begin
                next_rd_ptr = rd_ptr + PW'(1);
            end
            next_count = count + LW'(push) - LW'(pop);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push && !f.flush) begin
            mem[wr_ptr] <= f.in_data;
        end
    end

    assign f.in_ready = (count != LW'(DEPTH));
    assign f.out_valid = (count != '0);
    assign f.out_data = mem[rd_ptr];
    assign f.level = count;

endmodule : uhbt_fifo

// ---- rtl/uhbt_core.sv ----
// uhbt_core: host port, id readout, interrupt pin, baud generator, transmitter
// assumes: sys_clk is the oscillator clock; host pins are asynchronous to it

module uhbt_core #(
    parameter int FIFO_DEPTH = uhbt_pkg::TX_FIFO_DEPTH,
    parameter logic [7:0] DEVICE_ID = 8'h5A,  // arbitrary value
    parameter logic [7:0] REVISION_ID = 8'h0C  // arbitrary value
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic reset_pin,
    input wire logic bus_style_select,
    input wire logic cs_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic rw_dir,
    input wire logic [uhbt_pkg::ADDR_W-1:0] addr,
    input wire logic [uhbt_pkg::DATA_W-1:0] data_in,
    input wire logic rx_data_ready,
    input wire logic rx_above_trigger,
    output logic [uhbt_pkg::DATA_W-1:0] data_out,
    output logic data_oe_n,
    output logic int_out,
    output logic tx_serial,
    output logic osc_out
);
    import uhbt_pkg::*;

    generate
        if (FIFO_DEPTH < 16 || FIFO_DEPTH > 16) begin : g_bad_depth
            $error("uhbt_core: trigger table serves FIFO_DEPTH 16 only");
        end
    endgenerate

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    localparam int SW = 17;
    logic [SW-1:0] pin_s1, pin_s2;
    logic s_cs_n, s_rd_n, s_wr_n, s_rw, s_style, s_rst;
    logic [2:0] s_addr;
    logic [7:0] s_data;

    always_ff @(posedge sys_clk) begin
        pin_s1 <= {cs_n, read_strobe_n, write_strobe_n, rw_dir, addr, data_in,
                   bus_style_select, reset_pin};
        pin_s2 <= pin_s1;
    end

    assign {s_cs_n, s_rd_n, s_wr_n, s_rw, s_addr, s_data, s_style, s_rst} = pin_s2;

    // ----------------------------------------
    // reset pin
    // ----------------------------------------
    logic [1:0] rst_cnt, next_rst_cnt;
    logic pin_rst_act, rst;

    always_comb begin
        pin_rst_act = s_style ? s_rst : !s_rst;
        next_rst_cnt = pin_rst_act ? ((rst_cnt == 2'h3) ? rst_cnt : rst_cnt + 2'h1) : 2'h0;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rst_cnt <= 2'h0;
        end else begin
            rst_cnt <= next_rst_cnt;
        end
    end

    assign rst = srst || (32'(rst_cnt) >= RESET_MIN_CYC);

    // ----------------------------------------
    // host cycle decode
    // ----------------------------------------
    logic rd_act, wr_act, wr_act_q, next_wr_act_q, wr_pulse;
    logic [2:0] wr_addr, next_wr_addr;
    logic [7:0] wr_data, next_wr_data;

    always_comb begin
        rd_act = !s_cs_n && (s_style ? !s_rd_n : s_rw);
        wr_act = !s_cs_n && (s_style ? !s_wr_n : !s_rw);
        next_wr_act_q = wr_act;
        next_wr_addr = wr_act ? s_addr : wr_addr;
        next_wr_data = wr_act ? s_data : wr_data;
        wr_pulse = wr_act_q && !wr_act;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_act_q <= 1'b0;
            wr_addr <= 3'h0;
            wr_data <= 8'h00;
        end else begin
            wr_act_q <= next_wr_act_q;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] div_low, next_div_low, div_high, next_div_high, ier, next_ier;
    logic [7:0] fifo_control, next_fcr, lcr, next_lcr, modem_control, next_mcr, scratch_reg, next_spr;
    logic flush, next_flush, div_acc, fifo_en;
    logic [15:0] divisor;

    uhbt_fifo_if #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) txf ();

    assign div_acc = lcr[LCR_DIV_ACCESS];
    assign fifo_en = fifo_control[FCR_FIFO_EN];
    assign divisor = {div_high, div_low};

    always_comb begin
        next_div_low = div_low;
        next_div_high = div_high;
        next_ier = ier;
        next_fcr = fifo_control;
        next_lcr = lcr;
        next_mcr = modem_control;
        next_spr = scratch_reg;
        next_flush = 1'b0;
        if (wr_pulse) begin
            case (wr_addr)
                OFS_DATA: begin
                    if (div_acc) begin
                        next_div_low = wr_data;
                    end
                end
                OFS_IER: begin
                    if (div_acc) begin
                        next_div_high = wr_data;
                    end else begin
                        next_ier = wr_data;
                    end
                end
                OFS_FCR: begin
                    next_fcr = {wr_data[7:3], 2'b00, wr_data[0]};
                    next_flush = wr_data[FCR_TX_RESET] || (wr_data[0] != fifo_en);
                end
                OFS_LCR: next_lcr = wr_data;
                OFS_MCR: next_mcr = wr_data;
                OFS_SPR: next_spr = wr_data;
                default: next_spr = scratch_reg;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div_low <= DIV_LOW_RST;
            div_high <= DIV_HIGH_RST;
            ier <= IER_RST;
            fifo_control <= FCR_RST;
            lcr <= LCR_RST;
            modem_control <= MCR_RST;
            scratch_reg <= SPR_RST;
            flush <= 1'b0;
        end else begin
            div_low <= next_div_low;
            div_high <= next_div_high;
            ier <= next_ier;
            fifo_control <= next_fcr;
            lcr <= next_lcr;
            modem_control <= next_mcr;
            scratch_reg <= next_spr;
            flush <= next_flush;
        end
    end

    // holding write: one slot without fifo mode, full depth with it
    assign txf.in_valid = wr_pulse && (wr_addr == OFS_DATA) && !div_acc
                          && (fifo_en || txf.level == '0);
    assign txf.in_data = wr_data;
    assign txf.flush = flush;

    uhbt_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txfifo (
        .sys_clk(sys_clk),
        .srst(rst),
        .f(txf)
    );

    // ----------------------------------------
    // read path and interrupt pin
    // ----------------------------------------
    uhbt_tx_state_t state, next_state;
    logic [7:0] line_status, next_data_out;
    logic tx_cond, rx_cond, next_int_out;

    always_comb begin
        line_status = 8'h00;
        line_status[LSR_RX_READY] = rx_data_ready;
        line_status[LSR_THR_EMPTY] = (txf.level == '0);
        line_status[LSR_TX_EMPTY] = (txf.level == '0) && (state == TX_IDLE);
        case (s_addr)
            OFS_DATA: next_data_out = !div_acc ? 8'h00 :
                                      (divisor == 16'h0000) ? REVISION_ID : div_low;
            OFS_IER: next_data_out = !div_acc ? ier :
                                     (divisor == 16'h0000) ? DEVICE_ID : div_high;
            OFS_FCR: next_data_out = {{2{fifo_en}}, 6'h01};
            OFS_LCR: next_data_out = lcr;
            OFS_MCR: next_data_out = modem_control;
            OFS_LSR: next_data_out = line_status;
            OFS_SPR: next_data_out = scratch_reg;
            default: next_data_out = 8'h00;
        endcase
        tx_cond = ier[IER_TX_EN] && (fifo_en ?
                  (txf.level < uhbt_tx_trigger(fifo_control[5:4])) : (txf.level == '0));
        rx_cond = ier[IER_RX_EN] && (fifo_en ? rx_above_trigger : rx_data_ready);
        next_int_out = s_style ? (tx_cond || rx_cond) : !(tx_cond || rx_cond);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            data_out <= 8'h00;
            data_oe_n <= 1'b1;
            int_out <= 1'b0;
        end else begin
            data_out <= next_data_out;
            data_oe_n <= !rd_act;
            int_out <= next_int_out;
        end
    end

    // ----------------------------------------
    // prescaler and baud generator
    // ----------------------------------------
    logic [1:0] pre_cnt, next_pre_cnt;
    logic [15:0] div_cnt, next_div_cnt;
    logic pre_tick, tick16, next_osc_out;

    always_comb begin
        pre_tick = !modem_control[MCR_PRESCALE] || (pre_cnt == PRESCALE_SLOW_LAST);
        next_pre_cnt = pre_cnt + 2'h1;
        tick16 = pre_tick && (divisor != 16'h0000) && (div_cnt >= divisor - 16'h0001);
        next_div_cnt = tick16 ? 16'h0000 : pre_tick ? div_cnt + 16'h0001 : div_cnt;
        next_osc_out = !osc_out;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pre_cnt <= 2'h0;
            div_cnt <= 16'h0000;
            osc_out <= 1'b0;
        end else begin
            pre_cnt <= next_pre_cnt;
            div_cnt <= next_div_cnt;
            osc_out <= next_osc_out;
        end
    end

    // ----------------------------------------
    // transmitter
    // ----------------------------------------
    logic [3:0] tick_cnt, next_tick_cnt;
    logic [2:0] bit_idx, next_bit_idx;
    logic [7:0] shreg, next_shreg, mask;
    logic par, next_par, stop_idx, next_stop_idx, bit_end, next_tx_serial;

    assign txf.out_ready = (state == TX_IDLE) && tick16;
    assign mask = 8'hFF >> (2'h3 - lcr[1:0]);

    always_comb begin
        next_state = state;
        next_tick_cnt = tick_cnt;
        next_bit_idx = bit_idx;
        next_shreg = shreg;
        next_par = par;
        next_stop_idx = stop_idx;
        bit_end = tick16 && (tick_cnt == BIT_TICKS_LAST);
        if (tick16 && state != TX_IDLE) begin
            next_tick_cnt = tick_cnt + 4'h1;
        end
        case (state)
            TX_IDLE: begin
                if (txf.out_valid && tick16) begin
                    next_state = TX_START;
                    next_shreg = txf.out_data & mask;
                    next_par = lcr[LCR_PAR_EVEN] ? ^(txf.out_data & mask)
                                                 : ~^(txf.out_data & mask);
                    next_tick_cnt = 4'h0;
                    next_bit_idx = 3'h0;
                    next_stop_idx = 1'b0;
                end
            end
            TX_START: begin
                if (bit_end) begin
                    next_state = TX_DATA;
                end
            end
            TX_DATA: begin
                if (bit_end) begin
                    next_shreg = shreg >> 1;
                    next_bit_idx = bit_idx + 3'h1;
                    if (bit_idx == {1'b1, lcr[1:0]}) begin
                        next_state = lcr[LCR_PAR_EN] ? TX_PARITY : TX_STOP;
                    end
                end
            end
            TX_PARITY: begin
                if (bit_end) begin
                    next_state = TX_STOP;
                end
            end
            TX_STOP: begin
                if (bit_end) begin
                    next_stop_idx = 1'b1;
                    if (!lcr[LCR_STOP2] || stop_idx) begin
                        next_state = TX_IDLE;
                    end
                end
            end
            default: next_state = TX_IDLE;
        endcase
        case (next_state)
            TX_START: next_tx_serial = 1'b0;
            TX_DATA: next_tx_serial = next_shreg[0];
            TX_PARITY: next_tx_serial = next_par;
            default: next_tx_serial = 1'b1;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= TX_IDLE;
            tick_cnt <= 4'h0;
            bit_idx <= 3'h0;
            shreg <= 8'h00;
            par <= 1'b0;
            stop_idx <= 1'b0;
            tx_serial <= 1'b1;
        end else begin
            state <= next_state;
            tick_cnt <= next_tick_cnt;
            bit_idx <= next_bit_idx;
            shreg <= next_shreg;
            par <= next_par;
            stop_idx <= next_stop_idx;
            tx_serial <= next_tx_serial;
        end
    end

endmodule : uhbt_core

// ---- testbench/uhbt_core_chk.sv ----
// checker: port-level assertions for uhbt_core, bound below
// assumes: one sys_clk domain, srst synchronous active high
module uhbt_core_chk (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic reset_pin,
    input wire logic bus_style_select,
    input wire logic cs_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic rw_dir,
    input wire logic [uhbt_pkg::ADDR_W-1:0] addr,
    input wire logic [uhbt_pkg::DATA_W-1:0] data_out,
    input wire logic data_oe_n,
    input wire logic int_out,
    input wire logic tx_serial,
    input wire logic osc_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import uhbt_pkg::*;
    logic [31:0] low_run;
    logic [31:0] next_low_run;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    // ----------------------------------------
    // length of the current low run on tx_serial
    // ----------------------------------------
    always_comb begin
        next_low_run = (srst || tx_serial) ? 32'h0000_0000 : low_run + 32'h0000_0001;
    end
    always_ff @(posedge sys_clk) begin
        low_run <= next_low_run;
    end
    chk_reset_outs: assert property ($fell(srst) |-> tx_serial && data_oe_n && !osc_out
        && data_out == 8'h00) else $error("outputs off their reset values after srst");
    chk_osc_toggle: assert property (osc_out |=> !osc_out)
        else $error("osc_out high for two cycles");
    chk_bit_length: assert property ($rose(tx_serial) |-> low_run != 0 && low_run[3:0] == 4'h0)
        else $error("low run on tx_serial not whole 16-tick bits");
    chk_oe_idle: assert property (cs_n [*5] |-> data_oe_n)
        else $error("data bus driven without chip select");
    chk_oe_read: assert property (
        (!cs_n && (bus_style_select ? !read_strobe_n : rw_dir)) [*5] |-> !data_oe_n)
        else $error("read cycle did not drive the data bus");
    chk_int_polarity: assert property ($fell(srst) |=> (int_out == !bus_style_select) [*2])
        else $error("int_out not idle at its polarity after reset");
    chk_reset_pin: assert property ((reset_pin == bus_style_select) [*5] |=> tx_serial && data_oe_n)
        else $error("active reset_pin did not reset outputs");
    chk_scratch_hold: assert property (
        (!cs_n && !read_strobe_n && write_strobe_n && bus_style_select && addr == OFS_SPR) [*6]
        |-> $stable(data_out) && !data_oe_n) else $error("scratch read data moved");
endmodule : uhbt_core_chk

bind uhbt_core uhbt_core_chk chk_u (
    .sys_clk(sys_clk), .srst(srst), .reset_pin(reset_pin), .bus_style_select(bus_style_select),
    .cs_n(cs_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .rw_dir(rw_dir),
    .addr(addr), .data_out(data_out), .data_oe_n(data_oe_n), .int_out(int_out),
    .tx_serial(tx_serial), .osc_out(osc_out)
);

// ---- testbench/uhbt_host_model.sv ----
// host model: processor running cycles on the async 8-bit register port
// assumes: cycles launched on falling edges of sys_clk
module uhbt_host_model (
    input wire logic sys_clk,
    input wire logic bus_style_select,
    output logic cs_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic rw_dir,
    output logic [uhbt_pkg::ADDR_W-1:0] addr,
    output logic [uhbt_pkg::DATA_W-1:0] data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    import uhbt_pkg::*;
    initial begin
        {cs_n, read_strobe_n, write_strobe_n, rw_dir} = 4'hF;
        addr = 3'h0;
        data_in = 8'h00;
    end
    // one bus cycle: strobe held 7 clocks, then 5 idle; released data bus inverts
    task automatic cycle(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic rd);
        @(negedge sys_clk);
        addr = a;
        data_in = rd ? ~data_in : d;
        rw_dir = rd;
        {cs_n, read_strobe_n, write_strobe_n} = {1'h0, !(rd && bus_style_select), rd || !bus_style_select};
        repeat (7) @(negedge sys_clk);
        {cs_n, read_strobe_n, write_strobe_n} = 3'h7;
        data_in = ~data_in;
        repeat (5) @(negedge sys_clk);
    endtask : cycle
endmodule : uhbt_host_model

// ---- testbench/uart_host_baud_tx_core_test.sv ----
// testbench: host cycles, serial capture and interrupt checks for uhbt_core
// assumes: uhbt_host_model as bus partner, checker bound to uhbt_core
module uart_host_baud_tx_core_test;
    timeunit 1ns;
    timeprecision 1ns;
    import uhbt_pkg::*;
    localparam logic [7:0] TB_DEV_ID = 8'hA7;  // arbitrary value
    localparam logic [7:0] TB_REV_ID = 8'h3C;  // arbitrary value
    logic sys_clk, srst, reset_pin, bus_style_select, rx_data_ready, rx_above_trigger, par_on;
    logic cs_n, read_strobe_n, write_strobe_n, rw_dir, data_oe_n, int_out, tx_serial, osc_out;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_in, data_out, v;
    logic [7:0] rd_q[$], tx_q[$];
    int fail_count, checks, bit_cyc, seed;
    uhbt_core #(.DEVICE_ID(TB_DEV_ID), .REVISION_ID(TB_REV_ID)) dut_u (
        .sys_clk(sys_clk), .srst(srst), .reset_pin(reset_pin), .bus_style_select(bus_style_select),
        .cs_n(cs_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .rw_dir(rw_dir),
        .addr(addr), .data_in(data_in), .rx_data_ready(rx_data_ready),
        .rx_above_trigger(rx_above_trigger), .data_out(data_out), .data_oe_n(data_oe_n),
        .int_out(int_out), .tx_serial(tx_serial), .osc_out(osc_out)
    );
    uhbt_host_model host_u (
        .sys_clk(sys_clk), .bus_style_select(bus_style_select), .cs_n(cs_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .rw_dir(rw_dir),
        .addr(addr), .data_in(data_in)
    );
    always #25 sys_clk = ~sys_clk;
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic report_and_stop();
        if (rd_q.size() != 0 || tx_q.size() != 0)
            fail_count++;
        if (fail_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        host_u.cycle(a, d, 1'h0);
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        host_u.cycle(a, 8'h00, 1'h1);
    endtask : rd
    task automatic int_is(input logic e);
        repeat (8) @(negedge sys_clk);
        check("int_out", {7'h00, e}, {7'h00, int_out});
    endtask : int_is
    task automatic set_div(input logic [15:0] dv, input logic pre4);
        wr(OFS_LCR, 8'h80);
        wr(OFS_DATA, dv[7:0]);
        wr(OFS_IER, dv[15:8]);
        wr(OFS_LCR, 8'h03);
        wr(OFS_MCR, {pre4, 7'h00});
        bit_cyc = 16 * int'(dv) * (pre4 ? 4 : 1);
    endtask : set_div
    task automatic wait_tx();
        for (int i = 0; i < 40000 && tx_q.size() != 0; i++) @(negedge sys_clk);
        repeat (bit_cyc) @(negedge sys_clk);
    endtask : wait_tx
    // ----------------------------------------
    // output watchers
    // ----------------------------------------
    always @(negedge sys_clk) begin
        if ($fell(data_oe_n))
            check("data_out", rd_q.size() != 0 ? rd_q.pop_front() : 8'hxx, data_out);
    end
    always begin : serial_mon
        logic [7:0] got;
        @(negedge sys_clk iff (tx_serial === 1'h0 && srst === 1'h0));
        repeat (bit_cyc / 2) @(negedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(negedge sys_clk);
            got[i] = tx_serial;
        end
        if (par_on) begin
            repeat (bit_cyc) @(negedge sys_clk);
            check("parity_bit", {7'h00, ^got}, {7'h00, tx_serial});
        end
        repeat (bit_cyc) @(negedge sys_clk);
        check("stop_bit", 8'h01, {7'h00, tx_serial});
        check("tx_byte", tx_q.size() != 0 ? tx_q.pop_front() : 8'hxx, got);
    end
    initial begin
        repeat (60000) @(posedge sys_clk);
        fail_count++;
        report_and_stop();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        sys_clk = 1'h0;
        {srst, reset_pin, bus_style_select, rx_data_ready, rx_above_trigger, par_on} = 6'h28;
        bit_cyc = 16;
        seed = $urandom(46000);
        repeat (12) @(negedge sys_clk);
        srst = 1'h0;
        rd(OFS_LCR, LCR_RST);
        wr(OFS_LCR, 8'h80);
        rd(OFS_DATA, DIV_LOW_RST);
        rd(OFS_IER, DIV_HIGH_RST);
        wr(OFS_DATA, 8'h00);
        wr(OFS_IER, 8'h00);
        rd(OFS_IER, TB_DEV_ID);
        rd(OFS_DATA, TB_REV_ID);
        set_div(16'h0001, 1'h0);
        rd(OFS_DATA, 8'h00);
        repeat (4) begin
            v = 8'($urandom);
            wr(OFS_SPR, v);
            rd(OFS_SPR, v);
        end
        rd(OFS_LSR, 8'h60);
        for (int k = 0; k < 2; k++) begin
            wr(OFS_LCR, k ? 8'h1B : 8'h03);
            par_on = k[0];
            v = 8'($urandom);
            tx_q.push_back(v);
            wr(OFS_DATA, v);
            rd(OFS_LSR, 8'h20);
            wait_tx();
        end
        par_on = 1'h0;
        wr(OFS_LCR, 8'h03);
        rx_data_ready = 1'h1;
        rd(OFS_LSR, 8'h61);
        wr(OFS_IER, 8'h02);
        int_is(1'h1);
        wr(OFS_IER, 8'h01);
        int_is(1'h1);
        rx_data_ready = 1'h0;
        int_is(1'h0);
        wr(OFS_FCR, 8'h39);
        rd(OFS_FCR, 8'hC1);
        set_div(16'h0002, 1'h1);
        wr(OFS_IER, 8'h02);
        int_is(1'h1);
        repeat (18) begin
            v = 8'($urandom);
            if (tx_q.size() < 17)
                tx_q.push_back(v);
            wr(OFS_DATA, v);
        end
        int_is(1'h0);
        rd(OFS_LSR, 8'h00);
        wr(OFS_IER, 8'h01);
        rx_above_trigger = 1'h1;
        int_is(1'h1);
        rx_above_trigger = 1'h0;
        int_is(1'h0);
        wr(OFS_IER, 8'h02);
        wait_tx();
        int_is(1'h1);
        srst = 1'h1;
        bus_style_select = 1'h0;
        reset_pin = 1'h1;
        repeat (12) @(negedge sys_clk);
        srst = 1'h0;
        int_is(1'h1);
        wr(OFS_IER, 8'h02);
        int_is(1'h0);
        wr(OFS_SPR, 8'hA5);
        reset_pin = 1'h0;
        repeat (6) @(negedge sys_clk);
        reset_pin = 1'h1;
        int_is(1'h1);
        rd(OFS_SPR, SPR_RST);
        report_and_stop();
    end
endmodule : uart_host_baud_tx_core_test
